// file: copy_pkg.sv
package copy_pkg;
    // register file geometry
    localparam int GR_AW   = 5;
    localparam int FP_AW   = 2;
    localparam int WORD_W  = 32;
    localparam int EXT_W   = 80;
    localparam int EXC_W   = 4;
    // opcodes, register format
    localparam logic [11:0] OP_MODTC = 12'h654;
    localparam logic [11:0] OP_MOV   = 12'h5CC;
    localparam logic [11:0] OP_MOVL  = 12'h5DC;
    localparam logic [11:0] OP_MOVT  = 12'h5EC;
    localparam logic [11:0] OP_MOVQ  = 12'h5FC;
    localparam logic [11:0] OP_MOVR  = 12'h6C9;
    localparam logic [11:0] OP_MOVRL = 12'h6D9;
    localparam logic [11:0] OP_MOVRE = 12'h6E9;
    // word counts
    localparam logic [2:0] LEN_1 = 3'h1;
    localparam logic [2:0] LEN_2 = 3'h2;
    localparam logic [2:0] LEN_3 = 3'h3;
    localparam logic [2:0] LEN_4 = 3'h4;
    // trace controls
    localparam logic [31:0] TC_FIXED_MASK = 32'h00FF00FF;
    localparam logic [31:0] TC_RESET      = 32'h00000000;
    // real formats
    localparam int SGL_FW = 23;
    localparam int SGL_EW = 8;
    localparam int DBL_FW = 52;
    localparam int DBL_EW = 11;
    localparam int EXT_FW = 63;
    localparam int EXT_EW = 15;
    localparam int EXT_HI = 16;
    localparam logic [17:0] SGL_BIAS = 18'h0007F;
    localparam logic [17:0] DBL_BIAS = 18'h003FF;
    localparam logic [17:0] EXT_BIAS = 18'h03FFF;
    localparam logic [10:0] SGL_EMAX = 11'h0FF;
    localparam logic [10:0] DBL_EMAX = 11'h7FF;
    localparam logic [14:0] EXT_EMAX = 15'h7FFF;
    // exception flag positions
    localparam int EXC_INV = 3;
    localparam int EXC_OVF = 2;
    localparam int EXC_UNF = 1;
    localparam int EXC_INX = 0;
    typedef enum logic [1:0] {
        FLT_NONE, FLT_RESERVED, FLT_ARITH, FLT_OPCODE
    } fault_t;
endpackage

// file: register_copy_unit.sv
// Notes on behaviour
// [RQ1] opcode 654 updates trace controls, returns previous value to dst
// [RQ2] opcodes 5CC, 5DC, 5EC, 5FC copy one to four words
// [RQ3] multiword copies use consecutive registers from the named bases
// [RQ4] software aligns bases: even for two words, multiple of four else
// [RQ5] software keeps source and destination ranges disjoint
// [RQ6] opcodes 6C9, 6D9, 6E9 copy single, double, extended reals
// [RQ7] double real uses two general registers, extended uses three
// [RQ8] single/double moves convert to or from extended across files
// [RQ9] software converts single to double through a float register
// [RQ10] extended into float register drops top 16 bits of third word
// [RQ11] extended into general registers zeroes top 16 bits of third word
// [RQ12] extended copy moves bits only and never raises an exception
// [RQ13] unnormal operand with normalizing mode set gives reserved fault
// [RQ14] raised exception faults only when its mask bit is clear
// [RQ15] single/double copies flag overflow, underflow and inexact
// [RQ16] signalling not-a-number source flags invalid operation
// [RQ17] trace update uses mask ANDed with fixed pattern
module register_copy_unit (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    // instruction request
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire logic [11:0]                 req_opcode,
    input  wire logic [copy_pkg::GR_AW-1:0]  req_src1,
    input  wire logic [copy_pkg::GR_AW-1:0]  req_src2,
    input  wire logic [copy_pkg::GR_AW-1:0]  req_dst,
    input  wire logic                        req_src_fp,
    input  wire logic                        req_dst_fp,
    // arithmetic controls
    input  wire logic                        ac_norm_mode,
    input  wire logic [copy_pkg::EXC_W-1:0]  ac_exc_mask,
    // general register file
    output logic [copy_pkg::GR_AW-1:0]       gr_rd_addr,
    input  wire logic [copy_pkg::WORD_W-1:0] gr_rd_data,
    output logic                             gr_wr_en,
    output logic [copy_pkg::GR_AW-1:0]       gr_wr_addr,
    output logic [copy_pkg::WORD_W-1:0]      gr_wr_data,
    // floating-point register file
    output logic [copy_pkg::FP_AW-1:0]       fp_rd_idx,
    input  wire logic [copy_pkg::EXT_W-1:0]  fp_rd_data,
    output logic                             fp_wr_en,
    output logic [copy_pkg::FP_AW-1:0]       fp_wr_idx,
    output logic [copy_pkg::EXT_W-1:0]       fp_wr_data,
    // completion
    output logic                             done,
    output logic                             fault,
    output copy_pkg::fault_t                 fault_kind,
    output logic [copy_pkg::EXC_W-1:0]       exc_flags,
    output logic [copy_pkg::WORD_W-1:0]      trace_ctl
);
    import copy_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_READ, S_FPREAD, S_CONV, S_WRITE
    } state_t;
    typedef enum logic [1:0] {K_MOVE, K_REAL, K_TC} kind_t;

    state_t              state_q;
    kind_t               kind_q;
    logic [2:0]          len_q;
    logic [1:0]          cnt_q;
    logic [2:0]          wcnt_q;
    logic                src_fp_q;
    logic                dst_fp_q;
    logic [GR_AW-1:0]    src2_q;
    logic [GR_AW-1:0]    dst_q;
    logic [GR_AW-1:0]    rd_addr_q;
    logic [WORD_W-1:0]   w_q [4];
    logic [EXT_W-1:0]    ext_q;
    logic [WORD_W-1:0]   tc_q;
    logic                gr_wr_en_q;
    logic [GR_AW-1:0]    gr_wr_addr_q;
    logic [WORD_W-1:0]   gr_wr_data_q;
    logic                fp_wr_en_q;
    logic [FP_AW-1:0]    fp_wr_idx_q;
    logic [EXT_W-1:0]    fp_wr_data_q;
    logic                done_q;
    logic                fault_q;
    fault_t              fault_kind_q;
    logic [EXC_W-1:0]    exc_q;

    assign req_ready  = (state_q == S_IDLE);
    assign gr_rd_addr = rd_addr_q;
    assign fp_rd_idx  = rd_addr_q[FP_AW-1:0];
    assign gr_wr_en   = gr_wr_en_q;
    assign gr_wr_addr = gr_wr_addr_q;
    assign gr_wr_data = gr_wr_data_q;
    assign fp_wr_en   = fp_wr_en_q;
    assign fp_wr_idx  = fp_wr_idx_q;
    assign fp_wr_data = fp_wr_data_q;
    assign done       = done_q;
    assign fault      = fault_q;
    assign fault_kind = fault_kind_q;
    assign exc_flags  = exc_q;
    assign trace_ctl  = tc_q;

    ////////////////////////////////////////////////////////////////////
    // decode
    logic        dec_ok;
    kind_t       dec_kind;
    logic [2:0]  dec_len;

    always_comb begin
        dec_ok   = 1'b1;
        dec_kind = K_MOVE;
        dec_len  = LEN_1;
        case (req_opcode)
            OP_MODTC: begin
                dec_kind = K_TC; // RQ1
                dec_len  = LEN_2;
            end
            OP_MOV:   dec_len = LEN_1; // RQ2
            OP_MOVL:  dec_len = LEN_2; // RQ2
            OP_MOVT:  dec_len = LEN_3; // RQ2
            OP_MOVQ:  dec_len = LEN_4; // RQ2
            OP_MOVR: begin
                dec_kind = K_REAL; // RQ6
                dec_len  = LEN_1;
            end
            OP_MOVRL: begin
                dec_kind = K_REAL; // RQ6 RQ7
                dec_len  = LEN_2;
            end
            OP_MOVRE: begin
                dec_kind = K_REAL; // RQ6 RQ7
                dec_len  = LEN_3;
            end
            default:  dec_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // real format conversion
    logic              f_dbl, f_ext;
    logic [17:0]       bias;
    logic [10:0]       emax;
    logic [63:0]       v;
    logic              u_s, u_zero, u_den, u_spec, u_snan;
    logic [10:0]       u_e;
    logic [DBL_FW-1:0] u_f;
    logic [17:0]       u_xe;
    logic [EXT_W-1:0]  ext_from;
    logic              x_s, x_i, x_zero, x_spec, x_rsv, x_snan;
    logic [14:0]       x_e;
    logic [EXT_FW-1:0] x_f;
    logic [17:0]       e_t;
    logic              ovf, unf, lost;
    logic [10:0]       o_e;
    logic [DBL_FW-1:0] o_f;
    logic [63:0]       fmt_from;

    always_comb begin
        f_dbl = (len_q == LEN_2);
        f_ext = (len_q == LEN_3);
        bias  = f_dbl ? DBL_BIAS : SGL_BIAS;
        emax  = f_dbl ? DBL_EMAX : SGL_EMAX;
        v     = {w_q[1], w_q[0]};
        u_s   = f_dbl ? v[DBL_FW+DBL_EW] : v[SGL_FW+SGL_EW];
        u_e   = f_dbl ? v[DBL_FW+:DBL_EW] : 11'(v[SGL_FW+:SGL_EW]);
        u_f   = f_dbl ? v[DBL_FW-1:0]
                      : {v[SGL_FW-1:0], (DBL_FW-SGL_FW)'(0)};
        u_zero = (u_e == 11'h000) && (u_f == '0);
        u_den  = (u_e == 11'h000) && (u_f != '0);
        u_spec = (u_e == emax);
        u_snan = u_spec && (u_f != '0) && !u_f[DBL_FW-1];
        // denormals keep their value as an extended unnormal
        u_xe = u_den ? (EXT_BIAS - bias + 18'h00001)
                     : ({7'h00, u_e} + EXT_BIAS - bias);
        ext_from = {u_s,
                    u_zero ? 15'h0000 : u_spec ? EXT_EMAX : u_xe[14:0],
                    !u_zero && !u_den,
                    u_f | {u_snan, (DBL_FW-1)'(0)},
                    (EXT_FW-DBL_FW)'(0)}; // RQ8
        x_s    = ext_q[EXT_W-1];
        x_e    = ext_q[EXT_FW+1+:EXT_EW];
        x_i    = ext_q[EXT_FW];
        x_f    = ext_q[EXT_FW-1:0];
        x_zero = (x_e == 15'h0000) && !x_i && (x_f == '0);
        x_spec = (x_e == EXT_EMAX);
        x_rsv  = !x_spec && !x_zero && (!x_i || x_e == 15'h0000);
        x_snan = x_spec && (x_f != '0) && !x_f[EXT_FW-1];
        e_t    = {3'h0, x_e} + bias - EXT_BIAS;
        ovf = !x_spec && !x_zero && !x_rsv
              && ($signed(e_t) >= $signed({7'h00, emax})); // RQ15
        unf = !x_spec && !x_zero
              && (x_rsv || $signed(e_t) <= 18'sh00000); // RQ15
        lost = f_dbl ? (x_f[EXT_FW-DBL_FW-1:0] != '0)
                     : (x_f[EXT_FW-SGL_FW-1:0] != '0);
        o_e = (x_spec || ovf) ? emax
              : (x_zero || unf) ? 11'h000 : e_t[10:0];
        o_f = x_spec ? (x_f[EXT_FW-1-:DBL_FW]
                        | {x_snan, (DBL_FW-1)'(0)})
              : (ovf || unf) ? '0 : x_f[EXT_FW-1-:DBL_FW];
        fmt_from = f_dbl ? {x_s, o_e, o_f}
                 : {32'h00000000, x_s, o_e[SGL_EW-1:0],
                    o_f[DBL_FW-1-:SGL_FW]}; // RQ8
    end

    ////////////////////////////////////////////////////////////////////
    // exception and fault evaluation
    logic             rsv_c;
    logic [EXC_W-1:0] exc_c;
    logic             flt_c;

    always_comb begin
        rsv_c = 1'b0;
        exc_c = '0;
        if (kind_q == K_REAL && !f_ext) begin // RQ12
            if (src_fp_q) begin
                rsv_c          = x_rsv; // RQ13
                exc_c[EXC_INV] = x_snan; // RQ16
                if (!dst_fp_q) begin
                    exc_c[EXC_OVF] = ovf; // RQ15
                    exc_c[EXC_UNF] = unf && !x_rsv;
                    exc_c[EXC_INX] = !x_spec && !x_zero
                                     && (lost || ovf || unf);
                end
            end else begin
                rsv_c          = u_den; // RQ13
                exc_c[EXC_INV] = u_snan; // RQ16
            end
        end
        flt_c = (rsv_c && ac_norm_mode)
                || ((exc_c & ~ac_exc_mask) != '0); // RQ13 RQ14
    end

    ////////////////////////////////////////////////////////////////////
    // sequencing
    logic last_rd, last_wr;
    assign last_rd = ({1'b0, cnt_q} == len_q - LEN_1);
    assign last_wr = dst_fp_q || kind_q == K_TC || last_rd;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q   <= S_IDLE;
            cnt_q     <= '0;
            rd_addr_q <= '0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    cnt_q     <= '0;
                    rd_addr_q <= req_src1;
                    if (req_valid && dec_ok)
                        state_q <= (dec_kind == K_REAL && req_src_fp)
                                   ? S_FPREAD : S_READ;
                end
                S_READ: begin
                    cnt_q     <= cnt_q + 2'h1;
                    // consecutive source words; trace update reads src2
                    rd_addr_q <= (kind_q == K_TC) ? src2_q
                                 : rd_addr_q + GR_AW'(1); // RQ3
                    if (last_rd) state_q <= S_CONV;
                end
                S_FPREAD: state_q <= S_CONV;
                S_CONV: begin
                    cnt_q   <= '0;
                    state_q <= flt_c ? S_IDLE : S_WRITE;
                end
                S_WRITE: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (last_wr) state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            kind_q   <= K_MOVE;
            len_q    <= LEN_1;
            src_fp_q <= 1'b0;
            dst_fp_q <= 1'b0;
            src2_q   <= '0;
            dst_q    <= '0;
        end else if (state_q == S_IDLE && req_valid) begin
            kind_q   <= dec_kind;
            len_q    <= dec_len;
            src_fp_q <= req_src_fp && dec_kind == K_REAL;
            dst_fp_q <= req_dst_fp && dec_kind == K_REAL;
            src2_q   <= req_src2;
            dst_q    <= req_dst;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // operand buffer and trace controls
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            w_q   <= '{default: '0};
            ext_q <= '0;
        end else if (state_q == S_READ) begin
            w_q[cnt_q] <= gr_rd_data;
        end else if (state_q == S_FPREAD) begin
            ext_q <= fp_rd_data;
        end else if (state_q == S_CONV && kind_q == K_TC) begin
            w_q[0] <= tc_q; // RQ1
        end else if (state_q == S_CONV && kind_q == K_REAL) begin
            if (f_ext) begin
                if (src_fp_q) begin
                    w_q[0] <= ext_q[WORD_W-1:0];
                    w_q[1] <= ext_q[2*WORD_W-1:WORD_W];
                    w_q[2] <= {EXT_HI'(0), ext_q[EXT_W-1-:EXT_HI]}; // RQ11
                end else begin
                    // RQ10
                    ext_q <= {w_q[2][EXT_HI-1:0], w_q[1], w_q[0]};
                end
            end else if (src_fp_q && !dst_fp_q) begin
                {w_q[1], w_q[0]} <= fmt_from; // RQ8
            end else if (!src_fp_q && dst_fp_q) begin
                ext_q <= ext_from; // RQ8
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            tc_q <= TC_RESET;
        else if (state_q == S_CONV && kind_q == K_TC)
            tc_q <= (TC_FIXED_MASK & w_q[0] & w_q[1])
                    | (tc_q & ~(TC_FIXED_MASK & w_q[0])); // RQ17
    end

    ////////////////////////////////////////////////////////////////////
    // register file writes and completion
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gr_wr_en_q   <= 1'b0;
            gr_wr_addr_q <= '0;
            gr_wr_data_q <= '0;
            fp_wr_en_q   <= 1'b0;
            fp_wr_idx_q  <= '0;
            fp_wr_data_q <= '0;
        end else begin
            gr_wr_en_q <= state_q == S_WRITE && !dst_fp_q;
            fp_wr_en_q <= state_q == S_WRITE && dst_fp_q;
            if (state_q == S_WRITE) begin
                gr_wr_addr_q <= dst_q + GR_AW'(cnt_q); // RQ3
                gr_wr_data_q <= w_q[cnt_q];
                fp_wr_idx_q  <= dst_q[FP_AW-1:0];
                fp_wr_data_q <= ext_q;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            done_q       <= 1'b0;
            fault_q      <= 1'b0;
            fault_kind_q <= FLT_NONE;
            exc_q        <= '0;
            wcnt_q       <= '0;
        end else begin
            done_q  <= (state_q == S_WRITE && last_wr)
                       || (state_q == S_CONV && flt_c)
                       || (state_q == S_IDLE && req_valid && !dec_ok);
            fault_q <= (state_q == S_CONV && flt_c)
                       || (state_q == S_IDLE && req_valid && !dec_ok);
            // outcome of the last instruction holds until the next accept
            if (state_q == S_IDLE && req_valid) begin
                fault_kind_q <= dec_ok ? FLT_NONE : FLT_OPCODE;
                exc_q        <= '0;
            end else if (state_q == S_CONV) begin
                exc_q        <= exc_c; // RQ15 RQ16
                fault_kind_q <= !flt_c ? FLT_NONE
                    : (rsv_c && ac_norm_mode) ? FLT_RESERVED
                    : FLT_ARITH; // RQ13 RQ14
            end
            // idle clears first so an accept in the done cycle starts at 0
            if (state_q == S_IDLE)
                wcnt_q <= '0;
            else if (gr_wr_en_q)
                wcnt_q <= wcnt_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_tc_exec;
        state_q == S_CONV && kind_q == K_TC;
    endsequence
    sequence s_real_conv;
        state_q == S_CONV && kind_q == K_REAL && !f_ext;
    endsequence

    a_tc_old_value: assert property (s_tc_exec |-> ##2 gr_wr_en
        && gr_wr_data == $past(tc_q, 2)) // RQ1
        else $error("previous trace controls not returned");
    a_tc_fixed_bits: assert property (s_tc_exec |=>
        ((tc_q ^ $past(tc_q)) & ~TC_FIXED_MASK) == '0) // RQ17
        else $error("reserved trace bit changed");
    a_copy_words: assert property (done && !fault && kind_q == K_MOVE
        |-> gr_wr_en && wcnt_q + LEN_1 == len_q) // RQ2
        else $error("wrong number of words copied");
    a_write_consec: assert property (gr_wr_en ##1 gr_wr_en
        |-> gr_wr_addr == $past(gr_wr_addr) + GR_AW'(1)) // RQ3
        else $error("destination words not consecutive");
    a_ext_zero_top: assert property (gr_wr_en && kind_q == K_REAL
        && f_ext && src_fp_q && wcnt_q == LEN_2
        |-> gr_wr_data[WORD_W-1-:EXT_HI] == '0) // RQ11
        else $error("extended third word top not zero");
    a_ext_truncate: assert property (fp_wr_en && f_ext && !src_fp_q
        |-> fp_wr_data == {w_q[2][EXT_HI-1:0], w_q[1], w_q[0]}) // RQ10
        else $error("extended third word not truncated");
    a_ext_no_fault: assert property (done && kind_q == K_REAL && f_ext
        |-> !fault && exc_flags == '0) // RQ12
        else $error("extended copy raised an exception");
    a_reserved_flt: assert property (s_real_conv ##0 rsv_c && ac_norm_mode
        |=> done && fault && fault_kind == FLT_RESERVED) // RQ13
        else $error("reserved encoding fault missing");
    a_masked_quiet: assert property (s_real_conv ##0 !flt_c
        |=> !fault ##1 (gr_wr_en || fp_wr_en)) // RQ14
        else $error("masked exception faulted");
    a_snan_invalid: assert property (s_real_conv ##0 src_fp_q && x_snan
        |=> exc_flags[EXC_INV]) // RQ16
        else $error("signalling nan not flagged");
    a_ovf_flag: assert property (s_real_conv ##0 src_fp_q && !dst_fp_q
        && ovf |=> exc_flags[EXC_OVF] && exc_flags[EXC_INX]) // RQ15
        else $error("overflow not flagged");
endmodule

// file: register_copy_unit_tb_top.sv
module register_copy_unit_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import copy_pkg::*;

    logic              clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0;
    logic              req_src_fp = 1'b0, req_dst_fp = 1'b0;
    logic              ac_norm_mode = 1'b0;
    logic [11:0]       req_opcode = 12'h000;
    logic [GR_AW-1:0]  req_src1 = 5'h00, req_src2 = 5'h00, req_dst = 5'h00;
    logic [EXC_W-1:0]  ac_exc_mask = 4'hF;
    logic              req_ready, gr_wr_en, fp_wr_en, done, fault, fault_seen;
    logic [GR_AW-1:0]  gr_rd_addr, gr_wr_addr;
    logic [FP_AW-1:0]  fp_rd_idx, fp_wr_idx;
    logic [EXC_W-1:0]  exc_flags;
    logic [WORD_W-1:0] gr_rd_data, gr_wr_data, trace_ctl;
    logic [EXT_W-1:0]  fp_rd_data, fp_wr_data;
    fault_t            fault_kind, kind_seen;
    logic [WORD_W-1:0] gr [32];
    logic [EXT_W-1:0]  fp [4];
    int                nwr = 0, writes = 0;
    int                mismatches = 0, samples_checked = 0;

    register_copy_unit uut (
        .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_opcode(req_opcode),
        .req_src1(req_src1), .req_src2(req_src2), .req_dst(req_dst),
        .req_src_fp(req_src_fp), .req_dst_fp(req_dst_fp),
        .ac_norm_mode(ac_norm_mode), .ac_exc_mask(ac_exc_mask),
        .gr_rd_addr(gr_rd_addr), .gr_rd_data(gr_rd_data),
        .gr_wr_en(gr_wr_en), .gr_wr_addr(gr_wr_addr),
        .gr_wr_data(gr_wr_data), .fp_rd_idx(fp_rd_idx),
        .fp_rd_data(fp_rd_data), .fp_wr_en(fp_wr_en),
        .fp_wr_idx(fp_wr_idx), .fp_wr_data(fp_wr_data), .done(done),
        .fault(fault), .fault_kind(fault_kind), .exc_flags(exc_flags),
        .trace_ctl(trace_ctl)
    );

    //////////////////////////////////////////////////////////////////////
    always #5 clk_sys = ~clk_sys;
    // register files answer reads in the same cycle
    assign gr_rd_data = gr[gr_rd_addr];
    assign fp_rd_data = fp[fp_rd_idx];
    always @(posedge clk_sys) begin
        if (gr_wr_en) gr[gr_wr_addr] <= gr_wr_data;
        if (fp_wr_en) fp[fp_wr_idx] <= fp_wr_data;
        if (gr_wr_en || fp_wr_en) nwr <= nwr + 1;
    end

    task automatic check(input string what, input logic [79:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // one request, held over its take edge, then wait for done
    task automatic run(input logic [11:0] op, input logic [4:0] s1, s2, d,
                       input logic sfp, dfp, input logic [3:0] m,
                       input logic nm);
        int n0;
        int t;
        @(negedge clk_sys);
        n0 = nwr;
        req_opcode = op;
        req_src1 = s1;
        req_src2 = s2;
        req_dst = d;
        req_src_fp = sfp;
        req_dst_fp = dfp;
        ac_exc_mask = m;
        ac_norm_mode = nm;
        req_valid = 1'b1;
        @(negedge clk_sys);
        req_valid = 1'b0;
        t = 0;
        while (done !== 1'b1 && t < 40) begin
            @(negedge clk_sys);
            t++;
        end
        if (t == 40) check("done", done, 1'b1);
        fault_seen = fault;
        kind_seen = fault_kind;
        @(negedge clk_sys);
        writes = nwr - n0;
    endtask

    task automatic outcome(input fault_t k, input int w);
        check("fault", fault_seen, k != FLT_NONE);
        check("fault_kind", kind_seen, k);
        check("writes", writes, w);
    endtask

    //////////////////////////////////////////////////////////////////////
    task automatic t_int_copy();
        logic [11:0] ops [4];
        ops = '{OP_MOV, OP_MOVL, OP_MOVT, OP_MOVQ};
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 8; i++)
                gr[8 + i] = 32'hC0DE_0000 + 32'(k * 16 + i);
            run(ops[k], 5'h08, 5'h00, 5'h10, 1'b0, 1'b0, 4'hF, 1'b0);
            for (int i = 0; i <= k; i++)
                check("copy", gr[16 + i], gr[8 + i]);
            outcome(FLT_NONE, k + 1);
        end
        run(12'hFFF, 5'h08, 5'h00, 5'h10, 1'b0, 1'b0, 4'hF, 1'b0);
        outcome(FLT_OPCODE, 0);
    endtask

    task automatic t_trace();
        logic [31:0] exp;
        gr[12] = 32'hFFFF_0F0F;
        gr[10] = 32'h1234_5678;
        gr[2] = 32'hFFFF_FFFF;
        exp = gr[10] & gr[12] & 32'h00FF_00FF;
        run(OP_MODTC, 5'h0C, 5'h0A, 5'h02, 1'b0, 1'b0, 4'hF, 1'b0);
        check("old_tc", gr[2], 32'h0000_0000);
        check("trace_ctl", trace_ctl, exp);
        gr[12] = 32'hFFFF_FFFF;
        gr[10] = 32'h0000_0000;
        run(OP_MODTC, 5'h0C, 5'h0A, 5'h02, 1'b0, 1'b0, 4'hF, 1'b0);
        check("old_tc", gr[2], exp);
        check("trace_ctl", trace_ctl, 32'h0000_0000);
    endtask

    task automatic t_ext();
        // unnormal pattern, unmasked, normalizing: still no fault
        gr[4] = 32'h89AB_CDEF;
        gr[5] = 32'h0123_4567;
        gr[6] = 32'hDEAD_4001;
        run(OP_MOVRE, 5'h04, 5'h00, 5'h01, 1'b0, 1'b1, 4'h0, 1'b1);
        outcome(FLT_NONE, 1);
        check("exc_flags", exc_flags, 4'h0);
        check("fp_ext", fp[1], {16'h4001, gr[5], gr[4]});
        fp[2] = 80'hC000_8000_0000_0000_0001;
        gr[22] = 32'hFFFF_FFFF;
        run(OP_MOVRE, 5'h02, 5'h00, 5'h14, 1'b1, 1'b0, 4'h0, 1'b1);
        check("ext_w0", gr[20], 32'h0000_0001);
        check("ext_w1", gr[21], 32'h8000_0000);
        check("ext_w2", gr[22], 32'h0000_C000);
    endtask

    task automatic t_real();
        gr[3] = 32'h3F80_0000;
        run(OP_MOVR, 5'h03, 5'h00, 5'h02, 1'b0, 1'b1, 4'hF, 1'b0);
        check("sgl_to_ext", fp[2], 80'h3FFF_8000_0000_0000_0000);
        run(OP_MOVRL, 5'h02, 5'h00, 5'h18, 1'b1, 1'b0, 4'hF, 1'b0);
        check("dbl_lo", gr[24], 32'h0000_0000);
        check("dbl_hi", gr[25], 32'h3FF0_0000);
        fp[3] = 80'h3FFF_8000_0000_0000_0001;
        run(OP_MOVR, 5'h03, 5'h00, 5'h05, 1'b1, 1'b0, 4'hF, 1'b0);
        check("inexact", exc_flags[EXC_INX], 1'b1);
        check("trunc", gr[5], 32'h3F80_0000);
        run(OP_MOVR, 5'h03, 5'h00, 5'h05, 1'b1, 1'b0, 4'hE, 1'b0);
        outcome(FLT_ARITH, 0);
        fp[3] = 80'h7FFE_8000_0000_0000_0000;
        run(OP_MOVR, 5'h03, 5'h00, 5'h05, 1'b1, 1'b0, 4'hF, 1'b0);
        check("overflow", exc_flags[EXC_OVF], 1'b1);
        check("infinity", gr[5], 32'h7F80_0000);
        fp[3] = 80'h0001_8000_0000_0000_0000;
        run(OP_MOVR, 5'h03, 5'h00, 5'h05, 1'b1, 1'b0, 4'hF, 1'b0);
        check("underflow", exc_flags[EXC_UNF], 1'b1);
        gr[3] = 32'h7F80_0001;
        run(OP_MOVR, 5'h03, 5'h00, 5'h02, 1'b0, 1'b1, 4'hF, 1'b0);
        check("invalid", exc_flags[EXC_INV], 1'b1);
        run(OP_MOVR, 5'h03, 5'h00, 5'h02, 1'b0, 1'b1, 4'h7, 1'b0);
        outcome(FLT_ARITH, 0);
        gr[3] = 32'h0000_0001;
        run(OP_MOVR, 5'h03, 5'h00, 5'h02, 1'b0, 1'b1, 4'hF, 1'b1);
        outcome(FLT_RESERVED, 0);
        run(OP_MOVR, 5'h03, 5'h00, 5'h02, 1'b0, 1'b1, 4'hF, 1'b0);
        outcome(FLT_NONE, 1);
    endtask

    //////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 32; i++) gr[i] = 32'h0000_0000;
        for (int i = 0; i < 4; i++) fp[i] = 80'h0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        check("req_ready", req_ready, 1'b1);
        check("trace_ctl", trace_ctl, 32'h0000_0000);
        t_int_copy();
        t_trace();
        t_ext();
        t_real();
        summarize();
    end

    initial begin
        #50000;
        mismatches++;
        summarize();
    end
endmodule
